// ### logic/qrw_params.svh
`ifndef QRW_PARAMS_SVH
`define QRW_PARAMS_SVH

// ==========================================================
// Opcodes
`define QRW_OP_QIO      8'hEB
`define QRW_OP_QIO_DTR  8'hED
`define QRW_OP_QIO_4B   8'hEC
`define QRW_OP_SET_WRAP 8'h77

// ==========================================================
// Field positions and reset values
`define QRW_WRAP_RST      3'h1
`define QRW_WRAP_EN_BIT   0
`define QRW_SKIP_LSB      4
`define QRW_SKIP_VAL      2'h2
`define QRW_RDPARAM_RST   2'h0
`define QRW_ADDR3_MASK    32'h00FFFFFF
`define QRW_SECT_MIN      8'h08

// ==========================================================
// Phase lengths in nibbles or link clocks
`define QRW_SPI_OPC_BITS  4'h8
`define QRW_QPI_OPC_NIB   4'h2
`define QRW_ADDR3_NIB     4'h6
`define QRW_ADDR4_NIB     4'h8
`define QRW_BYTE_NIB      4'h2
`define QRW_SPI_DUMMY     4'h4
`define QRW_QPI_DUMMY_MIN 4'h2

`endif

// ### logic/qrw_pkg.sv
package qrw_pkg;

  // ==========================================================
  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_MODE,
    ST_WRAPB,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } qrw_state_e;

  typedef logic [31:0] qrw_addr_t;
  typedef logic [7:0]  qrw_byte_t;

endpackage

// ### logic/qrw_stream_if.sv
`timescale 1ns/1ps
interface qrw_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### logic/qrw_pin_sync.sv
`timescale 1ns/1ps
module qrw_pin_sync #(
  parameter int               WIDTH   = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // Two stages; only the second stage is visible outside
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### logic/qrw_fifo.sv
`timescale 1ns/1ps
module qrw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  qrw_stream_if.snk in_s,
  qrw_stream_if.src out_s
);

  // Depth must be a power of two: pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full_w;
  logic             empty_w;
  logic             push_w;
  logic             pop_w;

  // ==========================================================
  // Status and handshakes
  assign full_w      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty_w     = (wr_q == rd_q);
  assign push_w      = in_s.valid && !full_w;
  assign pop_w       = out_s.ready && !empty_w;
  assign in_s.ready  = !full_w;
  assign out_s.valid = !empty_w;
  assign out_s.data  = mem_q[rd_q[AW-1:0]];

  // Storage needs no reset, pointers define what is valid
  always_ff @(posedge clk) begin
    if (push_w) begin
      mem_q[wr_q[AW-1:0]] <= in_s.data;
    end
  end

  // Pointers; flush drops everything at frame end
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push_w);
      rd_q <= rd_q + (AW+1)'(pop_w);
    end
  end

  fifo_no_ovf_a: assert property (@(posedge clk) disable iff (rst)
    in_s.valid |-> in_s.ready)
    else $error("fifo written while full");

endmodule

// ### logic/qrw_engine.sv
// Function
// R1 - Wrap setting given before single-rate quad read governs all later such reads.
// R2 - Enabled wrap keeps output inside one aligned 8/16/32/64-byte section.
// R3 - Output starts at given address, wraps to section start until deselect.
// R4 - Three wrap bits: lowest disables wrap, upper two pick section length.
// R5 - Four-wire mode inserts 2, 4, 6 or 8 dummy clocks from parameter field.
// R6 - Four-wire dummy count defaults to two after reset.
// R7 - Four-wire mode counts mode byte as dummy; default data follows it.
// R8 - No wrap-around for quad reads in four-wire command mode.
// R9 - Double-rate read in SPI: address and data on four lines, four dummies.
// R10 - Mode byte follows address; upper nibble decides opcode skip, lower ignored.
// R11 - Mode bits 5:4 equal 10: next frame starts directly with address.
// R12 - Otherwise next frame expects a full opcode again.
// R13 - Host forces exit by all-ones on IO0 for 8 or 10 clocks.
// R14 - Host releases IO lines before falling edge of first data clock.
// R15 - Wrap setting governs later double-rate quad reads in SPI mode.
// R16 - Double-rate quad read also accepted in four-wire mode, mode byte as dummy.
// R17 - Fixed 4-byte read always carries a 32-bit address.
// R18 - Fixed 4-byte read accepted only in standard SPI mode.
// R19 - Wrap setting governs later fixed 4-byte quad reads.
// R20 - In 4-byte address mode the quad reads take a 32-bit address.
// R21 - Single-rate quad read refused unless four-line enable bit is set.
// R22 - Wrap command: opcode, 24/32 dummy bits, wrap byte using bits 6:4.
// R23 - Length codes 8/16/32/64 bytes; wrap disable bit resets to one.
// R24 - Section base is start address aligned down; only low bits increment.
// R25 - Reset clears pending continuous read mode.
`timescale 1ns/1ps
`include "qrw_params.svh"
module qrw_engine #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        spi_clk,
  input  wire logic        spi_cs_n,
  input  wire logic [3:0]  spi_io_in,
  output logic      [3:0]  spi_io_out_q,
  output logic      [3:0]  spi_io_oe_q,
  input  wire logic        four_wire_command_mode,
  input  wire logic        four_line_enable_bit,
  input  wire logic        addr_4byte_mode,
  input  wire logic        read_param_load,
  input  wire logic [1:0]  read_param_bits,
  output logic             mem_req_q,
  output logic      [31:0] mem_addr_q,
  input  wire logic        mem_gnt,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rvalid,
  output logic      [2:0]  wrap_setting_bits_q,
  output logic             opcode_skip_q,
  output logic             busy_q
);

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [5:0]         pin_s;
  logic               sclk_s;
  logic               cs_n_s;
  logic [3:0]         io_s;
  logic               sclk_p_q;
  logic               cs_p_q;
  logic               rise_w;
  logic               fall_w;
  logic               cs_fall_w;
  logic               frame_end_w;

  qrw_pin_sync #(.WIDTH(6), .RST_VAL(6'h10)) u_sync (
    .clk      (sys_clk),
    .rst      (rst),
    .async_in ({spi_clk, spi_cs_n, spi_io_in}),
    .sync_out (pin_s)
  );

  // Link clock, select and data all take the same two stages
  assign sclk_s      = pin_s[5];
  assign cs_n_s      = pin_s[4];
  assign io_s        = pin_s[3:0];
  assign rise_w      = sclk_s && !sclk_p_q;
  assign fall_w      = !sclk_s && sclk_p_q;
  assign cs_fall_w   = !cs_n_s && cs_p_q;
  assign frame_end_w = cs_n_s;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_p_q <= 1'b0;
      cs_p_q   <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      cs_p_q   <= cs_n_s;
    end
  end

  // ==========================================================
  // Sequencer state and captured fields
  qrw_pkg::qrw_state_e st_q;
  qrw_pkg::qrw_state_e st_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  qrw_pkg::qrw_byte_t  opc_q;
  qrw_pkg::qrw_addr_t  addr_q;
  qrw_pkg::qrw_byte_t  mode_q;
  logic                dtr_q;
  logic                ad4_q;
  logic                wrap_cmd_q;
  logic                wrap_on_q;
  logic [1:0]          rdp_q;
  logic                qpi_w;
  logic                in_evt_w;
  logic                step_w;
  qrw_pkg::qrw_byte_t  opc_nxt_w;
  qrw_pkg::qrw_addr_t  addr_nxt_w;
  qrw_pkg::qrw_byte_t  mode_nxt_w;
  logic                opc_last_w;
  logic                addr_last_w;
  logic                byte_last_w;
  logic                dummy_last_w;
  logic [3:0]          addr_nibs_w;
  logic [3:0]          dummy_len_w;
  logic                op_ok_w;
  logic                skip_ad4_w;

  assign qpi_w = four_wire_command_mode;

  // Double rate takes nibbles on both edges; a fall counts only after its own rise,
  // so the trailing fall of the last opcode clock is not taken as an address nibble
  assign in_evt_w   = rise_w || (dtr_q && fall_w && cnt_q[0]);
  assign opc_nxt_w  = qpi_w ? {opc_q[3:0], io_s} : {opc_q[6:0], io_s[0]};
  assign addr_nxt_w = {addr_q[27:0], io_s};
  assign mode_nxt_w = {mode_q[3:0], io_s};
  assign addr_nibs_w = ad4_q ? `QRW_ADDR4_NIB : `QRW_ADDR3_NIB; // [R17] [R20]

  // Dummy clocks left after the mode byte; in four-wire mode it eats some
  assign dummy_len_w = qpi_w ? ({1'b0, rdp_q, 1'b0} + `QRW_QPI_DUMMY_MIN - (dtr_q ? 4'h1 : 4'h2)) // [R5] [R7] [R16]
                             : `QRW_SPI_DUMMY; // [R9]

  assign opc_last_w   = (st_q == qrw_pkg::ST_OPC) && rise_w &&
                        (cnt_q == (qpi_w ? `QRW_QPI_OPC_NIB : `QRW_SPI_OPC_BITS) - 4'h1);
  assign addr_last_w  = (st_q == qrw_pkg::ST_ADDR) && in_evt_w && (cnt_q == addr_nibs_w - 4'h1);
  assign byte_last_w  = ((st_q == qrw_pkg::ST_MODE) || (st_q == qrw_pkg::ST_WRAPB)) &&
                        in_evt_w && (cnt_q == `QRW_BYTE_NIB - 4'h1);
  assign dummy_last_w = (st_q == qrw_pkg::ST_DUMMY) && rise_w && (cnt_q == dummy_len_w - 4'h1);

  // Opcode acceptance per mode
  assign op_ok_w = ((opc_nxt_w == `QRW_OP_QIO) && four_line_enable_bit) || // [R21]
                   (opc_nxt_w == `QRW_OP_QIO_DTR) ||                        // [R9] [R16]
                   ((opc_nxt_w == `QRW_OP_QIO_4B) && !qpi_w) ||             // [R18]
                   ((opc_nxt_w == `QRW_OP_SET_WRAP) && !qpi_w);
  assign skip_ad4_w = (opc_q == `QRW_OP_QIO_4B) || addr_4byte_mode;

  // Event counter: cleared on every state change
  assign step_w = ((st_q == qrw_pkg::ST_OPC) && rise_w) ||
                  (((st_q == qrw_pkg::ST_ADDR) || (st_q == qrw_pkg::ST_MODE) ||
                    (st_q == qrw_pkg::ST_WRAPB)) && in_evt_w) ||
                  ((st_q == qrw_pkg::ST_DUMMY) && rise_w);
  assign cnt_d  = (st_d != st_q) ? 4'h0 : cnt_q + {3'h0, step_w};

  // Next state; deselect wins over everything
  always_comb begin
    st_d = st_q;
    case (st_q)
      qrw_pkg::ST_IDLE: begin
        if (cs_fall_w) begin
          st_d = opcode_skip_q ? qrw_pkg::ST_ADDR : qrw_pkg::ST_OPC; // [R11] [R12]
        end
      end
      qrw_pkg::ST_OPC: begin
        if (opc_last_w) begin
          st_d = op_ok_w ? qrw_pkg::ST_ADDR : qrw_pkg::ST_IGNORE;
        end
      end
      qrw_pkg::ST_ADDR: begin
        if (addr_last_w) begin
          st_d = wrap_cmd_q ? qrw_pkg::ST_WRAPB : qrw_pkg::ST_MODE; // [R22] [R10]
        end
      end
      qrw_pkg::ST_MODE: begin
        if (byte_last_w) begin
          st_d = (dummy_len_w == 4'h0) ? qrw_pkg::ST_DATA : qrw_pkg::ST_DUMMY; // [R7]
        end
      end
      qrw_pkg::ST_WRAPB: begin
        if (byte_last_w) begin
          st_d = qrw_pkg::ST_IGNORE;
        end
      end
      qrw_pkg::ST_DUMMY: begin
        if (dummy_last_w) begin
          st_d = qrw_pkg::ST_DATA;
        end
      end
      qrw_pkg::ST_DATA:   st_d = qrw_pkg::ST_DATA;
      qrw_pkg::ST_IGNORE: st_d = qrw_pkg::ST_IGNORE;
      default:            st_d = qrw_pkg::ST_IDLE;
    endcase
    if (frame_end_w) begin
      st_d = qrw_pkg::ST_IDLE; // [R3]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q  <= qrw_pkg::ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Shift registers for opcode, address and mode or wrap byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opc_q  <= 8'h00;
      addr_q <= 32'h0000_0000;
      mode_q <= 8'h00;
    end else begin
      if ((st_q == qrw_pkg::ST_OPC) && rise_w) opc_q <= opc_nxt_w;
      if ((st_q == qrw_pkg::ST_ADDR) && in_evt_w) addr_q <= addr_nxt_w;
      if (step_w && (st_q != qrw_pkg::ST_ADDR)) mode_q <= mode_nxt_w;
    end
  end

  // Per-frame attributes; a skipped opcode reuses the last read's kind
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dtr_q      <= 1'b0;
      ad4_q      <= 1'b0;
      wrap_cmd_q <= 1'b0;
    end else if (opc_last_w) begin
      dtr_q      <= (opc_nxt_w == `QRW_OP_QIO_DTR);
      ad4_q      <= (opc_nxt_w == `QRW_OP_QIO_4B) || addr_4byte_mode; // [R17] [R20]
      wrap_cmd_q <= (opc_nxt_w == `QRW_OP_SET_WRAP);
    end else if ((st_q == qrw_pkg::ST_IDLE) && cs_fall_w && opcode_skip_q) begin
      ad4_q      <= skip_ad4_w;
      wrap_cmd_q <= 1'b0;
    end
  end

  // ==========================================================
  // Persistent settings: continuous mode, wrap bits, read parameter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opcode_skip_q       <= 1'b0;           // [R25]
      wrap_setting_bits_q <= `QRW_WRAP_RST;  // [R23]
      rdp_q               <= `QRW_RDPARAM_RST; // [R6]
    end else begin
      if (byte_last_w && (st_q == qrw_pkg::ST_MODE)) begin
        opcode_skip_q <= (mode_nxt_w[`QRW_SKIP_LSB+1:`QRW_SKIP_LSB] == `QRW_SKIP_VAL); // [R10] [R11] [R12]
      end
      if (byte_last_w && (st_q == qrw_pkg::ST_WRAPB)) begin
        wrap_setting_bits_q <= mode_nxt_w[6:4]; // [R1] [R4] [R22] [R15] [R19]
      end
      if (read_param_load) rdp_q <= read_param_bits; // [R5]
    end
  end

  // ==========================================================
  // Prefetch: one request in flight, gated by FIFO room
  qrw_stream_if #(.WIDTH(8)) fill_if ();
  qrw_stream_if #(.WIDTH(8)) drain_if ();
  logic               fetch_on_q;
  logic               pend_q;
  logic [7:0]         mask_w;
  qrw_pkg::qrw_addr_t sec_base_w;
  logic               adv_w;

  // Section mask 07/0F/1F/3F; sections never cross a page
  assign mask_w     = 8'((`QRW_SECT_MIN << wrap_setting_bits_q[2:1]) - 8'h01); // [R2] [R23]
  assign sec_base_w = mem_addr_q & {24'hFF_FFFF, ~mask_w};
  assign adv_w      = mem_req_q && mem_gnt;

  // Wrapped increment keeps the base and bumps only the low bits
  function automatic qrw_pkg::qrw_addr_t next_fetch(input qrw_pkg::qrw_addr_t a,
                                                    input logic [7:0] m,
                                                    input logic w);
    qrw_pkg::qrw_addr_t inc;
    inc = a + 32'h1;
    next_fetch = w ? ((a & {24'hFF_FFFF, ~m}) | (inc & {24'h0, m})) : inc;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_on_q <= 1'b0;
      wrap_on_q  <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
    end else if (frame_end_w) begin
      fetch_on_q <= 1'b0;
    end else if (addr_last_w && !wrap_cmd_q) begin
      fetch_on_q <= 1'b1;
      wrap_on_q  <= !wrap_setting_bits_q[`QRW_WRAP_EN_BIT] && !qpi_w; // [R8] [R1] [R15] [R19]
      mem_addr_q <= ad4_q ? addr_nxt_w : (addr_nxt_w & `QRW_ADDR3_MASK); // [R3]
    end else if (adv_w) begin
      mem_addr_q <= next_fetch(mem_addr_q, mask_w, wrap_on_q); // [R24] [R2]
    end
  end

  // Request only when nothing is in flight and the FIFO has room
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_req_q <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      mem_req_q <= !frame_end_w && ((mem_req_q && !mem_gnt) ||
                   (!mem_req_q && !pend_q && fetch_on_q && fill_if.ready));
      pend_q    <= adv_w ? 1'b1 : (mem_rvalid ? 1'b0 : pend_q);
    end
  end

  assign fill_if.valid = mem_rvalid && fetch_on_q;
  assign fill_if.data  = mem_rdata;

  qrw_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (sys_clk),
    .rst   (rst),
    .flush (frame_end_w),
    .in_s  (fill_if),
    .out_s (drain_if)
  );

  // ==========================================================
  // Output shifter: high nibble first, falling edges (both for DTR)
  logic               drv_evt_w;
  logic               nib_lo_q;
  qrw_pkg::qrw_byte_t byte_q;
  qrw_pkg::qrw_byte_t pop_byte_w;

  assign drv_evt_w      = (st_q == qrw_pkg::ST_DATA) && !frame_end_w && (fall_w || (dtr_q && rise_w)); // [R9]
  assign drain_if.ready = drv_evt_w && !nib_lo_q;
  // Underrun shows as FFh rather than stale data
  assign pop_byte_w     = drain_if.valid ? drain_if.data : 8'hFF;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nib_lo_q     <= 1'b0;
      byte_q       <= 8'hFF;
      spi_io_out_q <= 4'h0;
      spi_io_oe_q  <= 4'h0;
      busy_q       <= 1'b0;
    end else begin
      busy_q <= (st_d != qrw_pkg::ST_IDLE);
      if (frame_end_w) begin
        nib_lo_q    <= 1'b0;
        spi_io_oe_q <= 4'h0;
      end else if (drv_evt_w) begin
        nib_lo_q     <= !nib_lo_q;
        spi_io_oe_q  <= 4'hF; // [R14]
        spi_io_out_q <= nib_lo_q ? byte_q[3:0] : pop_byte_w[7:4];
        if (!nib_lo_q) byte_q <= pop_byte_w;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence mode_done_s;
    byte_last_w && (st_q == qrw_pkg::ST_MODE) && !frame_end_w;
  endsequence
  sequence opc_seen_s(logic [7:0] op);
    opc_last_w && !frame_end_w && (opc_nxt_w == op);
  endsequence

  reset_defaults_a: assert property ($fell(rst) |-> (rdp_q == 2'h0) && !opcode_skip_q && // [R6] [R25]
    (wrap_setting_bits_q == 3'h1)) else $error("reset values wrong");
  skip_entry_a: assert property (cs_fall_w && opcode_skip_q |=> st_q == qrw_pkg::ST_ADDR) // [R11]
    else $error("skip frame did not start with address");
  opcode_entry_a: assert property (cs_fall_w && !opcode_skip_q |=> st_q == qrw_pkg::ST_OPC) // [R12]
    else $error("frame did not expect opcode");
  mode_latch_a: assert property (mode_done_s |=> opcode_skip_q == (mode_q[5:4] == 2'h2)) // [R10]
    else $error("skip flag not taken from mode byte");
  qe_reject_a: assert property (opc_seen_s(8'hEB) ##0 !four_line_enable_bit // [R21]
    |=> st_q == qrw_pkg::ST_IGNORE) else $error("quad read taken without enable");
  ec_qpi_reject_a: assert property (opc_seen_s(8'hEC) ##0 qpi_w |=> st_q == qrw_pkg::ST_IGNORE) // [R18]
    else $error("4-byte read taken in four-wire mode");
  ec_addr32_a: assert property (opc_seen_s(8'hEC) ##0 !qpi_w |=> ad4_q) // [R17]
    else $error("4-byte read without 32-bit address");
  spi_dummy_a: assert property (mode_done_s ##0 !qpi_w |=> st_q == qrw_pkg::ST_DUMMY) // [R9]
    else $error("no dummy clocks in SPI read");
  qpi_nodummy_a: assert property (mode_done_s ##0 qpi_w && !dtr_q && (rdp_q == 2'h0) // [R7]
    |=> st_q == qrw_pkg::ST_DATA) else $error("default four-wire data not right after mode");
  qpi_nowrap_a: assert property (addr_last_w && !wrap_cmd_q && qpi_w |=> !wrap_on_q) // [R8]
    else $error("wrap enabled in four-wire mode");
  wrap_latch_a: assert property (byte_last_w && (st_q == qrw_pkg::ST_WRAPB) |=> // [R4]
    wrap_setting_bits_q == mode_q[6:4]) else $error("wrap bits not latched");
  section_hold_a: assert property (adv_w && wrap_on_q |=> $stable(sec_base_w)) // [R24]
    else $error("fetch left wrap section");
  oe_in_data_a: assert property (spi_io_oe_q != 4'h0 |-> st_q == qrw_pkg::ST_DATA) // [R14]
    else $error("IO driven outside data phase");

endmodule

// ### tb/qrw_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Quad link host: clock, select, four lines
module qrw_host_model (
  output logic            spi_clk,
  output logic            spi_cs_n,
  output logic      [3:0] spi_io_in,
  input  wire logic [3:0] spi_io_out_q,
  input  wire logic [3:0] spi_io_oe_q
);
  logic [3:0] hq;
  logic       hoe;
  logic [3:0] gn [0:31];

  // Released lines toggle so a stale value cannot pass
  assign spi_io_in = (|spi_io_oe_q) ? spi_io_out_q : hoe ? hq : {4{spi_clk}} ^ 4'hA;

  // Idle link: clock parked low, deselected
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    hoe      = 1'b0;
    hq       = 4'h0;
  end

  // Select changes only with the clock parked low
  task automatic sel(input logic s);
    #40 spi_cs_n = ~s;
    hoe = s;
    #40;
  endtask

  // One link clock; v1 follows the rise for double rate
  task automatic cyc(input logic [3:0] v0, input logic [3:0] v1, input logic dd, input logic rel);
    #20 hq = v0;
    #20 spi_clk = 1'b1;
    #20 if (dd) hq = v1;
    if (rel) hoe = 1'b0;
    #20 spi_clk = 1'b0;
  endtask

  // Each nibble is sampled late, just before it may change
  task automatic rdat(input logic dd, input int n);
    for (int j = 0; j < 2 * n; j++) begin
      if (!dd) #40 spi_clk = 1'b1;
      #35 gn[j] = spi_io_in;
      #5 spi_clk = dd ? ~spi_clk : 1'b0;
    end
    spi_clk = 1'b0;
  endtask

  // Forced exit from continuous reads
  task automatic leave;
    sel(1'b1);
    repeat (8) cyc(4'h1, 4'h0, 1'b0, 1'b0);
    sel(1'b0);
  endtask
endmodule

// ### tb/quad_io_read_wrap_engine_bench.sv
`timescale 1ns/1ps
`include "qrw_params.svh"
module quad_io_read_wrap_engine_bench;
  typedef struct packed {
    logic [7:0] op;
    logic       fw;
    logic       a4;
    logic [7:0] w;
    logic [3:0] dum;
  } qrw_row_s;
  logic        sys_clk, rst, spi_clk, spi_cs_n, fwm, qen, a4, pld;
  logic        mem_req_q, mem_gnt, mem_rvalid, skip, busy, drove;
  logic [1:0]  pbits;
  logic [2:0]  wsb, wexp;
  logic [3:0]  sio, oq, oe;
  logic [7:0]  mdat;
  logic [31:0] maddr;
  int          mismatches, samples_checked;
  qrw_row_s    rows [0:7];

  // ==========================================
  // Design, host and memory
  qrw_engine i_qrw_engine (.sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_io_in(sio), .spi_io_out_q(oq), .spi_io_oe_q(oe), .four_wire_command_mode(fwm),
    .four_line_enable_bit(qen), .addr_4byte_mode(a4), .read_param_load(pld), .read_param_bits(pbits),
    .mem_req_q(mem_req_q), .mem_addr_q(maddr), .mem_gnt(mem_gnt), .mem_rdata(mdat),
    .mem_rvalid(mem_rvalid), .wrap_setting_bits_q(wsb), .opcode_skip_q(skip), .busy_q(busy));
  qrw_host_model i_qrw_host_model (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_io_in(sio),
    .spi_io_out_q(oq), .spi_io_oe_q(oe));

  always #5 sys_clk = ~sys_clk;

  // Memory grants at once and answers one cycle later
  assign mem_gnt = mem_req_q;
  always @(posedge sys_clk) begin
    mem_rvalid <= #1 mem_req_q & mem_gnt;
    mdat <= #1 dat(maddr);
    if (|oe) drove <= 1'b1;
  end

  // Upper address bytes mix in so a truncated address shows
  function automatic logic [7:0] dat(input logic [31:0] a);
    dat = a[7:0] ^ a[15:8] ^ a[31:24];
  endfunction

  function automatic logic [31:0] nxt(input logic [31:0] a, input logic [2:0] w, input logic f);
    logic [31:0] m;
    m = (32'h8 << w[2:1]) - 32'h1;
    nxt = (!w[0] && !f) ? ((a & ~m) | ((a + 32'h1) & m)) : a + 32'h1;
  endfunction

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end
    else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rstc;
    @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 wexp = 3'h1;
  endtask

  task automatic opc(input logic [7:0] op);
    if (fwm) begin
      i_qrw_host_model.cyc(op[7:4], 4'h0, 1'b0, 1'b0);
      i_qrw_host_model.cyc(op[3:0], 4'h0, 1'b0, 1'b0);
    end
    else begin
      for (int i = 7; i >= 0; i--) i_qrw_host_model.cyc({3'h0, op[i]}, 4'h0, 1'b0, 1'b0);
    end
  endtask

  task automatic setw(input logic [7:0] w);
    i_qrw_host_model.sel(1'b1);
    opc(`QRW_OP_SET_WRAP);
    repeat (a4 ? 8 : 6) i_qrw_host_model.cyc(4'h0, 4'h0, 1'b0, 1'b0);
    i_qrw_host_model.cyc(w[7:4], 4'h0, 1'b0, 1'b0);
    i_qrw_host_model.cyc(w[3:0], 4'h0, 1'b0, 1'b0);
    i_qrw_host_model.sel(1'b0);
  endtask

  // One read frame; bytes are compared only when ok is set
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] m, input logic sk,
                    input int dum, input int n, input logic ok);
    logic        dd;
    logic [31:0] sh, e;
    int          na;
    dd = (op == `QRW_OP_QIO_DTR);
    na = (op == `QRW_OP_QIO_4B || a4) ? 8 : 6;
    e = (na == 8) ? a : a & `QRW_ADDR3_MASK;
    sh = a << (32 - 4 * na);
    drove = 1'b0;
    i_qrw_host_model.sel(1'b1);
    if (!sk) opc(op);
    for (int i = 0; i < na; i += dd ? 2 : 1) begin
      i_qrw_host_model.cyc(sh[31:28], sh[27:24], dd, 1'b0);
      sh = sh << (dd ? 8 : 4);
    end
    if (dd) i_qrw_host_model.cyc(m[7:4], m[3:0], 1'b1, 1'b0);
    else begin
      i_qrw_host_model.cyc(m[7:4], 4'h0, 1'b0, 1'b0);
      i_qrw_host_model.cyc(m[3:0], 4'h0, 1'b0, dum == 0);
    end
    for (int i = 1; i <= dum; i++) i_qrw_host_model.cyc(4'hF, 4'hF, 1'b0, i == dum);
    i_qrw_host_model.rdat(dd, n);
    i_qrw_host_model.sel(1'b0);
    for (int k = 0; k < n && ok; k++) begin
      chk({i_qrw_host_model.gn[2*k], i_qrw_host_model.gn[2*k+1]}, dat(e));
      e = nxt(e, wexp, fwm);
    end
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge sys_clk);
    #1 chk(8'(busy), 8'h0);
    if (busy !== 1'b0) wrap_up();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {sys_clk, rst, fwm, a4, pld, mem_rvalid, drove} = '0;
    qen = 1'b1;
    rst = 1'b1;
    pbits = 2'h0;
    mdat = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    rows = '{{8'hEB, 2'h0, 8'h10, 4'h4}, {8'hEB, 2'h0, 8'h00, 4'h4}, {8'hEB, 2'h0, 8'h20, 4'h4},
             {8'hED, 2'h0, 8'h40, 4'h4}, {8'hEC, 2'h0, 8'h60, 4'h4}, {8'hEB, 2'h1, 8'h30, 4'h4},
             {8'hEB, 2'h2, 8'h00, 4'h0}, {8'hED, 2'h2, 8'h00, 4'h1}};
    rstc();
    chk(8'(wsb), 8'h01);
    chk(8'(skip), 8'h00);
    chk(8'(oe), 8'h00);
    foreach (rows[r]) begin
      fwm = 1'b0;
      a4 = rows[r].a4;
      setw(rows[r].w);
      chk(8'(wsb), 8'(rows[r].w[6:4]));
      wexp = rows[r].w[6:4];
      fwm = rows[r].fw;
      rd(rows[r].op, 32'h01ABCD3D, 8'hFF, 1'b0, rows[r].dum, 10, 1'b1);
      chk(8'(skip), 8'h00);
      $display("row %0d done", r);
    end
    // Longest dummy setting: six clocks beyond the mode byte
    pld = 1'b1;
    pbits = 2'h3;
    @(posedge sys_clk);
    #1 pld = 1'b0;
    rd(`QRW_OP_QIO, 32'h00001234, 8'hFF, 1'b0, 6, 4, 1'b1);
    rd(`QRW_OP_QIO_4B, 32'h0, 8'hFF, 1'b0, 0, 2, 1'b0);
    chk(8'(drove), 8'h00);
    fwm = 1'b0;
    qen = 1'b0;
    rd(`QRW_OP_QIO, 32'h0, 8'hFF, 1'b0, 4, 2, 1'b0);
    chk(8'(drove), 8'h00);
    qen = 1'b1;
    $display("refusal test done");
    // Continuous reads, then the forced exit
    rd(`QRW_OP_QIO, 32'h00000100, 8'h20, 1'b0, 4, 3, 1'b1);
    chk(8'(skip), 8'h01);
    rd(`QRW_OP_QIO, 32'h00000200, 8'hAF, 1'b1, 4, 3, 1'b1);
    chk(8'(skip), 8'h01);
    i_qrw_host_model.leave();
    repeat (4) @(posedge sys_clk);
    #1 chk(8'(skip), 8'h00);
    rd(`QRW_OP_QIO, 32'h00000300, 8'hFF, 1'b0, 4, 3, 1'b1);
    $display("continuous test done");
    // Reset with continuous mode pending and long dummies set
    rd(`QRW_OP_QIO, 32'h00000400, 8'h20, 1'b0, 4, 2, 1'b1);
    pld = 1'b1;
    @(posedge sys_clk);
    #1 pld = 1'b0;
    rstc();
    chk(8'(skip), 8'h00);
    chk(8'(wsb), 8'h01);
    fwm = 1'b1;
    rd(`QRW_OP_QIO, 32'h00000500, 8'hFF, 1'b0, 0, 3, 1'b1);
    $display("reset test done");
    wrap_up();
  end

  // Watchdog against a hung run
  initial begin
    #400000;
    mismatches++;
    $display("BAD %0t run did not finish", $time);
    wrap_up();
  end
endmodule
